// ### logic/speed_loop_and_speed_detect.sv
module speed_loop_and_speed_detect #(
    parameter int unsigned SAMPLE_FAST_CYC = speed_pkg::SAMPLE_FAST_US * speed_pkg::CLK_MHZ,
    parameter int unsigned SAMPLE_SLOW_CYC = speed_pkg::SAMPLE_SLOW_US * speed_pkg::CLK_MHZ
) (
    // clock and reset
    input  wire logic                                    i_clk,
    input  wire logic                                    i_reset,
    // drive mode
    input  wire logic                                    i_enable,
    input  wire logic                                    i_closed_loop,
    input  speed_pkg::variant_e                          i_variant,
    input  speed_pkg::sw_freq_e                          i_sw_freq,
    // detector setup
    input  wire logic                                    i_detect_abs,
    input  wire logic                                    i_band_custom,
    input  wire logic [speed_pkg::SPD_W-1:0]             i_band_low,
    input  wire logic [speed_pkg::SPD_W-1:0]             i_band_up,
    input  wire logic                                    i_ovs_custom,
    input  wire logic [speed_pkg::SPD_W-1:0]             i_ovs_thr,
    input  wire logic                                    i_trip_reset,
    // regulator setup
    input  wire logic                                    i_gain_custom,
    input  wire logic [speed_pkg::GAIN_W-1:0]            i_p_coeff,
    input  wire logic [speed_pkg::GAIN_W-1:0]            i_i_coeff,
    input  wire logic [speed_pkg::GAIN_W-1:0]            i_d_coeff,
    input  wire logic [speed_pkg::GAIN_W-1:0]            i_pct_gain,
    // speed quantities
    input  wire logic signed [speed_pkg::SPD_W-1:0]      i_out_freq,
    input  wire logic signed [speed_pkg::SPD_W-1:0]      i_ref_pre_ramp,
    input  wire logic signed [speed_pkg::SPD_W-1:0]      i_speed_demand,
    // feedback device
    input  wire logic                                    i_fb_resolver,
    input  wire logic [3:0]                              i_enc_lines_log2,
    input  wire logic                                    i_enc_pulse,
    input  wire logic                                    i_enc_dir,
    input  wire logic [speed_pkg::SPD_W-1:0]             i_res_angle,
    // status
    output logic                                         o_overspeed_trip,
    output logic                                         o_at_speed,
    output logic                                         o_above_band,
    output logic                                         o_below_band,
    output logic                                         o_sample_tick,
    // regulator results
    output logic signed [speed_pkg::SPD_W-1:0]           o_speed_fb,
    output logic signed [speed_pkg::FB_W-1:0]            o_speed_err,
    output logic signed [speed_pkg::OUT_W-1:0]           o_loop_out,
    output logic signed [speed_pkg::PCT_W-1:0]           o_torque_pct
);
    import speed_pkg::*;

    typedef struct packed {
        state_e                  st;
        logic                    enc_s1;
        logic                    enc_s2;
        logic                    enc_s3;
        logic                    dir_s1;
        logic                    dir_s2;
        logic signed [SPD_W-1:0] run_cnt;
        logic signed [SPD_W-1:0] snap_cnt;
        logic [SPD_W-1:0]        res_prev;
        logic signed [SPD_W-1:0] res_diff;
        logic signed [FB_W-1:0]  fb;
        logic signed [FB_W-1:0]  fb_prev;
        logic signed [FB_W-1:0]  fb_path;
        logic signed [FB_W-1:0]  err;
        logic signed [ACC_W-1:0] acc;
        logic signed [OUT_W-1:0] out;
        logic signed [PCT_W-1:0] pct;
        logic signed [SPD_W-1:0] rpm;
        logic                    at_speed;
        logic                    above;
        logic                    below;
        logic                    flags_ok;
        logic                    trip;
    } state_s;

    state_s q;
    state_s n;

    logic                    tick;
    logic                    slow;
    logic                    run_loop;
    logic                    step;
    logic [GAIN_W-1:0]       p_eff;
    logic [GAIN_W-1:0]       i_eff;
    logic [GAIN_W-1:0]       d_eff;
    logic [SPD_W-1:0]        cmp_mag;
    logic [SPD_W-1:0]        ovs_thr;
    logic [SPD_W-1:0]        band_lo;
    logic [SPD_W-1:0]        band_hi;
    logic signed [W40-1:0]   norm;
    logic signed [W40-1:0]   dterm;
    logic signed [W40-1:0]   dem;
    logic signed [W40-1:0]   p_term;
    logic signed [W40-1:0]   i_term;
    logic signed [W40-1:0]   i_inc;
    logic signed [W40-1:0]   acc_sum;
    logic signed [W40-1:0]   out_sum;
    logic signed [W40-1:0]   pct_prod;

    function automatic logic signed [W40-1:0] clamp(input logic signed [W40-1:0] v,
                                                    input logic signed [W40-1:0] lim);
        if (v > lim) begin
            return lim;
        end else if (v < -lim) begin
            return -lim;
        end
        return v;
    endfunction

    function automatic logic signed [W40-1:0] s40u(input logic [GAIN_W-1:0] u);
        return $signed({24'h00_0000, u});
    endfunction

    function automatic logic [GAIN_W-1:0] gain_sel(input logic              custom,
                                                   input logic [GAIN_W-1:0] val,
                                                   input logic [GAIN_W-1:0] def);
        logic [GAIN_W-1:0] g;
        g = custom ? val : def;
        return (g > GAIN_MAX) ? GAIN_MAX : g;
    endfunction

    function automatic logic [SPD_W-1:0] mag16(input logic signed [SPD_W-1:0] v);
        return v[SPD_W-1] ? SPD_W'(-v) : SPD_W'(v);
    endfunction

    // sample period timer
    sample_tick #(
        .FAST_CYC (SAMPLE_FAST_CYC),
        .SLOW_CYC (SAMPLE_SLOW_CYC)
    ) u_tick (
        .i_clk     (i_clk),
        .i_reset   (i_reset),
        .i_sw_freq (i_sw_freq),
        .o_tick    (tick)
    );

    window_if win ();

    window_detect u_win (
        .win (win.det)
    );

    assign slow     = is_slow(i_sw_freq);
    assign run_loop = i_enable && i_closed_loop;
    assign step     = q.enc_s2 && !q.enc_s3;

    assign i_eff = gain_sel(i_gain_custom, i_i_coeff, I_COEFF_DEF);
    assign d_eff = gain_sel(i_gain_custom, i_d_coeff, D_COEFF_DEF);
    assign p_eff = (gain_sel(i_gain_custom, i_p_coeff, P_COEFF_DEF) < P_COEFF_MIN)
                   ? P_COEFF_MIN : gain_sel(i_gain_custom, i_p_coeff, P_COEFF_DEF);

    assign band_lo = i_band_custom ? i_band_low : (i_closed_loop ? BAND_CLOSED_DEF : BAND_OPEN_DEF);
    assign band_hi = i_band_custom ? i_band_up : (i_closed_loop ? BAND_CLOSED_DEF : BAND_OPEN_DEF);

    always_comb begin
        ovs_thr = OVS_OPEN_DEF;
        if (i_ovs_custom) begin
            ovs_thr = i_ovs_thr;
        end else begin
            case (i_variant)
                VAR_VECTOR: ovs_thr = OVS_VECTOR_DEF;
                VAR_SERVO:  ovs_thr = OVS_SERVO_DEF;
                default:    ovs_thr = OVS_OPEN_DEF;
            endcase
        end
    end

    assign cmp_mag = i_closed_loop ? mag16(q.rpm) : mag16(i_out_freq);

    assign win.ref_mag  = mag16(i_ref_pre_ramp);
    assign win.mag      = cmp_mag;
    assign win.lim_lo   = band_lo;
    assign win.lim_hi   = band_hi;
    assign win.abs_mode = i_detect_abs;

    always_comb begin
        n        = q;
        norm     = '0;
        dterm    = '0;
        dem      = '0;
        p_term   = '0;
        i_term   = '0;
        i_inc    = '0;
        acc_sum  = '0;
        out_sum  = '0;
        pct_prod = '0;
        n.enc_s1 = i_enc_pulse;
        n.enc_s2 = q.enc_s1;
        n.enc_s3 = q.enc_s2;
        n.dir_s1 = i_enc_dir;
        n.dir_s2 = q.dir_s1;
        if (step) begin
            n.run_cnt = q.dir_s2 ? q.run_cnt - 1'b1 : q.run_cnt + 1'b1;
        end
        case (q.st)
            ST_WAIT: begin
                if (tick) begin
                    n.snap_cnt = q.run_cnt;
                    n.run_cnt  = n.run_cnt - q.run_cnt;
                    n.res_diff = $signed(i_res_angle - q.res_prev);
                    n.res_prev = i_res_angle;
                    n.st       = ST_CAPTURE;
                end
            end
            ST_CAPTURE: begin
                if (i_fb_resolver) begin
                    norm = W40'(q.res_diff) >>> RES_SHIFT;
                end else begin
                    norm = W40'(q.snap_cnt) <<< (FB_NORM_LOG2 - i_enc_lines_log2);
                end
                if (slow) begin
                    norm = (norm * SLOW_MUL) >>> SLOW_SHIFT;
                end
                norm      = clamp(norm, FB_LIM);
                n.fb      = FB_W'(norm);
                n.fb_prev = q.fb;
                n.rpm     = SPD_W'(clamp((norm * RPM_Q8) >>> Q8, SPD_LIM));
                n.st      = ST_CALC;
            end
            ST_CALC: begin
                dterm = (s40u(d_eff) * (W40'(q.fb) - W40'(q.fb_prev))) >>> D_SHIFT;
                if (slow) begin
                    dterm = (dterm * SLOW_MUL) >>> SLOW_SHIFT;
                end
                n.fb_path = FB_W'(clamp(W40'(q.fb) + dterm, FB_LIM));
                dem       = (W40'(i_speed_demand) * DEM_Q16) >>> Q16;
                n.err     = FB_W'(clamp(dem - W40'(n.fb_path), FB_LIM));
                n.at_speed = win.at_speed;
                n.above    = win.above;
                n.below    = win.below;
                n.flags_ok = 1'b1;
                n.st       = ST_OUT;
            end
            ST_OUT: begin
                i_inc = W40'(q.err);
                if (slow) begin
                    i_inc = (i_inc * I_SLOW_Q8) >>> Q8;
                end
                acc_sum = clamp(W40'(q.acc) + i_inc, ACC_LIM);
                p_term  = (s40u(p_eff) * W40'(q.err)) >>> P_SHIFT;
                i_term  = (s40u(i_eff) * acc_sum) >>> I_SHIFT;
                out_sum = clamp(p_term + i_term, OUT_LIM);
                pct_prod = clamp((out_sum * s40u(i_pct_gain)) >>> PCT_SHIFT, PCT_LIM);
                n.acc = ACC_W'(acc_sum);
                n.out = OUT_W'(out_sum);
                n.pct = PCT_W'(pct_prod);
                n.st  = ST_WAIT;
            end
            default: begin
                n.st = ST_WAIT;
            end
        endcase
        if (!run_loop) begin
            n.acc = '0;
            n.out = '0;
            n.pct = '0;
        end
        if (i_trip_reset) begin
            n.trip = 1'b0;
        end
        if (q.st == ST_CALC && cmp_mag > ovs_thr) begin
            n.trip = 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign o_overspeed_trip = q.trip;
    assign o_at_speed       = q.at_speed;
    assign o_above_band     = q.above;
    assign o_below_band     = q.below;
    assign o_sample_tick    = tick;
    assign o_speed_fb       = q.rpm;
    assign o_speed_err      = q.err;
    assign o_loop_out       = q.out;
    assign o_torque_pct     = q.pct;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    sequence s_walk;
        q.st == ST_CAPTURE ##1 q.st == ST_CALC ##1 q.st == ST_OUT ##1 q.st == ST_WAIT;
    endsequence

    a_sample_walk: assert property ((q.st == ST_WAIT && tick) |=> s_walk)
        else $error("sample sequence broken");

    a_trip_set: assert property ((q.st == ST_CALC && cmp_mag > ovs_thr) |=> o_overspeed_trip)
        else $error("overspeed not tripped");

    a_trip_hold: assert property ((o_overspeed_trip && !i_trip_reset) |=> o_overspeed_trip)
        else $error("trip dropped without reset");

    a_flags_stable: assert property ((q.st != ST_CALC) |=> $stable({o_at_speed, o_above_band, o_below_band}))
        else $error("flags changed between samples");

    a_band_excl: assert property (q.flags_ok |-> (o_at_speed == !(o_above_band || o_below_band)))
        else $error("band flags inconsistent");

    a_abs_window: assert property ((q.st == ST_CALC && i_detect_abs && cmp_mag >= band_lo
                                    && cmp_mag <= band_hi) |=> o_at_speed)
        else $error("absolute window missed");

    a_ref_window: assert property ((q.st == ST_CALC && !i_detect_abs
                                    && {1'b0, cmp_mag} > {1'b0, win.ref_mag} + {1'b0, band_hi}) |=> o_above_band)
        else $error("reference window above missed");

    a_out_range: assert property (o_loop_out <= $signed(OUT_W'(OUT_LIM)) && o_loop_out >= -$signed(OUT_W'(OUT_LIM)))
        else $error("loop output out of range");

    a_pct_range: assert property (W40'(o_torque_pct) <= PCT_LIM && W40'(o_torque_pct) >= -PCT_LIM)
        else $error("torque percent out of range");

    a_disable_clr: assert property (!run_loop |=> (q.acc == '0 && o_loop_out == '0))
        else $error("integrator not cleared");

    a_p_floor: assert property (p_eff >= P_COEFF_MIN && p_eff <= GAIN_MAX)
        else $error("proportional gain out of range");
endmodule

// ### logic/speed_pkg.sv
package speed_pkg;

    localparam int unsigned CLK_MHZ        = 32'h0000_0019;
    localparam int unsigned SAMPLE_FAST_US = 32'h0000_0159;
    localparam int unsigned SAMPLE_SLOW_US = 32'h0000_01CC;

    localparam int unsigned SPD_W  = 16;
    localparam int unsigned GAIN_W = 16;
    localparam int unsigned FB_W   = 18;
    localparam int unsigned ACC_W  = 24;
    localparam int unsigned OUT_W  = 12;
    localparam int unsigned PCT_W  = 9;
    localparam int unsigned W40    = 40;

    localparam logic [GAIN_W-1:0] GAIN_MAX    = 16'h7D00;
    localparam logic [GAIN_W-1:0] P_COEFF_DEF = 16'h00C8;
    localparam logic [GAIN_W-1:0] I_COEFF_DEF = 16'h0064;
    localparam logic [GAIN_W-1:0] D_COEFF_DEF = 16'h0000;
    localparam logic [GAIN_W-1:0] P_COEFF_MIN = 16'h0001;

    localparam logic [SPD_W-1:0] OVS_OPEN_DEF   = 16'h2710;
    localparam logic [SPD_W-1:0] OVS_VECTOR_DEF = 16'h07D0;
    localparam logic [SPD_W-1:0] OVS_SERVO_DEF  = 16'h0FA0;
    localparam logic [SPD_W-1:0] BAND_OPEN_DEF  = 16'h000A;
    localparam logic [SPD_W-1:0] BAND_CLOSED_DEF = 16'h0005;

    localparam logic [3:0] FB_NORM_LOG2 = 4'hE;
    localparam int unsigned RES_SHIFT = 2;
    localparam int unsigned P_SHIFT   = 4;
    localparam int unsigned I_SHIFT   = 8;
    localparam int unsigned D_SHIFT   = 4;
    localparam int unsigned PCT_SHIFT = 10;
    localparam int unsigned Q8        = 8;
    localparam int unsigned Q16       = 16;
    localparam int unsigned SLOW_SHIFT = 2;

    localparam logic signed [W40-1:0] OUT_LIM   = 40'sh00_0000_07FE;
    localparam logic signed [W40-1:0] PCT_LIM   = 40'sh00_0000_00C8;
    localparam logic signed [W40-1:0] ACC_LIM   = 40'sh00_007F_FFFF;
    localparam logic signed [W40-1:0] FB_LIM    = 40'sh00_0001_FFFF;
    localparam logic signed [W40-1:0] SPD_LIM   = 40'sh00_0000_7FFF;
    localparam logic signed [W40-1:0] RPM_Q8    = 40'sh00_0000_0A9D;
    localparam logic signed [W40-1:0] DEM_Q16   = 40'sh00_0000_181E;
    localparam logic signed [W40-1:0] SLOW_MUL  = 40'sh00_0000_0003;
    localparam logic signed [W40-1:0] I_SLOW_Q8 = 40'sh00_0000_0155;

    typedef enum logic [1:0] {
        VAR_OPEN   = 2'h0,
        VAR_VECTOR = 2'h1,
        VAR_SERVO  = 2'h2
    } variant_e;

    typedef enum logic [2:0] {
        SW_3K  = 3'h0,
        SW_4K5 = 3'h1,
        SW_6K  = 3'h2,
        SW_9K  = 3'h3,
        SW_12K = 3'h4
    } sw_freq_e;

    typedef enum logic [1:0] {
        ST_WAIT    = 2'h0,
        ST_CAPTURE = 2'h1,
        ST_CALC    = 2'h3,
        ST_OUT     = 2'h2
    } state_e;

    function automatic logic is_slow(input sw_freq_e f);
        return (f == SW_4K5) || (f == SW_9K);
    endfunction

endpackage

// ### logic/window_if.sv
interface window_if;
    import speed_pkg::*;
    logic [SPD_W-1:0] mag;
    logic [SPD_W-1:0] ref_mag;
    logic [SPD_W-1:0] lim_lo;
    logic [SPD_W-1:0] lim_hi;
    logic             abs_mode;
    logic             at_speed;
    logic             above;
    logic             below;
    modport det  (input mag, ref_mag, lim_lo, lim_hi, abs_mode, output at_speed, above, below);
    modport user (output mag, ref_mag, lim_lo, lim_hi, abs_mode, input at_speed, above, below);
endinterface

// ### logic/window_detect.sv
module window_detect (
    window_if.det win
);
    import speed_pkg::*;

    logic signed [SPD_W+1:0] lo;
    logic signed [SPD_W+1:0] hi;
    logic signed [SPD_W+1:0] m;

    always_comb begin
        m = $signed({2'h0, win.mag});
        if (win.abs_mode) begin
            lo = $signed({2'h0, win.lim_lo});
            hi = $signed({2'h0, win.lim_hi});
        end else begin
            lo = $signed({2'h0, win.ref_mag}) - $signed({2'h0, win.lim_lo});
            hi = $signed({2'h0, win.ref_mag}) + $signed({2'h0, win.lim_hi});
        end
    end

    assign win.below    = m < lo;
    assign win.above    = m > hi;
    assign win.at_speed = !(m < lo) && !(m > hi);
endmodule

// ### logic/sample_tick.sv
module sample_tick #(
    parameter int unsigned FAST_CYC = speed_pkg::SAMPLE_FAST_US * speed_pkg::CLK_MHZ,
    parameter int unsigned SLOW_CYC = speed_pkg::SAMPLE_SLOW_US * speed_pkg::CLK_MHZ
) (
    // clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_reset,
    // period select
    input  speed_pkg::sw_freq_e     i_sw_freq,
    // tick
    output logic                    o_tick
);
    import speed_pkg::*;

    localparam int unsigned CNT_W = $clog2(SLOW_CYC + 1);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             tick;
    } tick_s;

    tick_s q;
    tick_s n;

    always_comb begin
        n = q;
        n.tick = 1'b0;
        if (q.cnt == '0) begin
            n.cnt  = is_slow(i_sw_freq) ? CNT_W'(SLOW_CYC - 1) : CNT_W'(FAST_CYC - 1);
            n.tick = 1'b1;
        end else begin
            n.cnt = q.cnt - 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign o_tick = q.tick;

    a_tick_gap: assert property (@(posedge i_clk) disable iff (i_reset)
        o_tick |=> (!o_tick) [*8])
        else $error("sample ticks too close");
endmodule

// ### dv/enc_model.sv
module enc_model (
    // clock and sample tick
    input  wire logic       i_clk,
    input  wire logic       i_tick,
    // pulses per window and direction
    input  wire logic [3:0] i_count,
    input  wire logic       i_dir,
    // encoder pins
    output logic            o_pulse,
    output logic            o_dir
);
    timeunit 1ns;
    timeprecision 1ns;
    int left = 0;
    int ph   = 0;
    always @(posedge i_clk) begin
        if (i_tick) begin
            left <= i_count;
            ph   <= 0;
        end else if (left > 0) begin
            ph <= (ph == 3) ? 0 : ph + 1;
            if (ph == 3) left <= left - 1;
        end
    end
    assign o_pulse = (left > 0) && (ph < 2);
    assign o_dir   = i_dir;
endmodule

// ### dv/speed_loop_and_speed_detect_tb_top.sv
module speed_loop_and_speed_detect_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import speed_pkg::*;
    logic i_clk = 0, i_reset = 1, i_enable = 0, i_closed_loop = 0, i_detect_abs = 0;
    logic i_band_custom = 1, i_ovs_custom = 1, i_trip_reset = 0, i_gain_custom = 0;
    logic i_fb_resolver = 0, dir = 0;
    variant_e i_variant = VAR_OPEN;
    sw_freq_e i_sw_freq = SW_3K;
    logic [15:0] i_band_low = 16'h0064, i_band_up = 16'h00C8, i_ovs_thr = 16'h7FFF;
    logic [15:0] i_p_coeff = 16'h0000, i_i_coeff = 16'h0000, i_d_coeff = 16'h0000;
    logic [15:0] i_pct_gain = 16'h0400, i_res_angle = 16'h0000;
    logic signed [15:0] i_out_freq = 16'h0000, i_ref_pre_ramp = 16'h0000, i_speed_demand = 16'h0000;
    logic [3:0] i_enc_lines_log2 = 4'hE, cnt = 4'h5;
    logic i_enc_pulse, i_enc_dir, o_overspeed_trip, o_at_speed, o_above_band, o_below_band, o_sample_tick;
    logic signed [15:0] o_speed_fb;
    logic signed [17:0] o_speed_err;
    logic signed [11:0] o_loop_out;
    logic signed [8:0]  o_torque_pct;
    int miscompares = 0, total_checks = 0, n;

    always #20 i_clk = ~i_clk;

    speed_loop_and_speed_detect #(.SAMPLE_FAST_CYC(40), .SAMPLE_SLOW_CYC(60)) DUT (
        .i_clk, .i_reset, .i_enable, .i_closed_loop, .i_variant, .i_sw_freq, .i_detect_abs,
        .i_band_custom, .i_band_low, .i_band_up, .i_ovs_custom, .i_ovs_thr, .i_trip_reset,
        .i_gain_custom, .i_p_coeff, .i_i_coeff, .i_d_coeff, .i_pct_gain, .i_out_freq,
        .i_ref_pre_ramp, .i_speed_demand, .i_fb_resolver, .i_enc_lines_log2, .i_enc_pulse,
        .i_enc_dir, .i_res_angle, .o_overspeed_trip, .o_at_speed, .o_above_band, .o_below_band,
        .o_sample_tick, .o_speed_fb, .o_speed_err, .o_loop_out, .o_torque_pct);

    enc_model feedback (.i_clk, .i_tick(o_sample_tick), .i_count(cnt), .i_dir(dir),
        .o_pulse(i_enc_pulse), .o_dir(i_enc_dir));

    task automatic chk(input string name, input logic [17:0] exp, input logic [17:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // waits for a tick, then lets all results land
    task automatic sample();
        n = 0;
        do begin
            @(negedge i_clk);
            n++;
        end while (o_sample_tick !== 1'b1 && n < 200);
        if (o_sample_tick !== 1'b1) begin
            miscompares++;
            $display("ERROR sample_tick expected 1 seen %b", o_sample_tick);
        end
        repeat (5) @(negedge i_clk);
    endtask

    task automatic settle();
        repeat (3) sample();
    endtask

    task automatic win(input logic abs_m, input int rf, input int f, input logic [2:0] exp);
        i_detect_abs   = abs_m;
        i_ref_pre_ramp = 16'(rf);
        i_out_freq     = 16'(f);
        sample();
        chk("flags", {15'h0000, exp}, {15'h0000, o_at_speed, o_above_band, o_below_band});
    endtask

    task automatic summarize();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #(20000 * 40);
        miscompares++;
        summarize();
    end

    initial begin
        repeat (8) @(negedge i_clk);
        i_reset = 0;
        chk("loop_rst", 18'h00000, {6'h00, o_loop_out});
        sample();
        sample();
        chk("period_fast", 18'h00028, 18'(n + 5));
        i_sw_freq = SW_9K;
        sample();
        sample();
        chk("period_slow", 18'h0003C, 18'(n + 5));
        i_sw_freq = SW_3K;
        win(1, 0, -150, 3'h4);
        win(1, 0, 100, 3'h4);
        win(1, 0, 200, 3'h4);
        win(1, 0, -201, 3'h2);
        win(1, 0, 99, 3'h1);
        i_band_low = 16'h000A;
        i_band_up  = 16'h0014;
        win(0, -500, 490, 3'h4);
        win(0, -500, -520, 3'h4);
        win(0, -500, 521, 3'h2);
        win(0, -500, 489, 3'h1);
        i_ovs_thr  = 16'h03E8;
        i_out_freq = 16'sh03E8;
        sample();
        chk("trip_eq", 18'h00000, {17'h00000, o_overspeed_trip});
        i_out_freq = 16'sh03E9;
        sample();
        chk("trip_set", 18'h00001, {17'h00000, o_overspeed_trip});
        i_out_freq   = 16'sh0000;
        i_trip_reset = 1;
        repeat (2) @(negedge i_clk);
        i_trip_reset = 0;
        chk("trip_clr", 18'h00000, {17'h00000, o_overspeed_trip});
        i_ovs_custom = 0;
        i_out_freq   = 16'sh2711;
        sample();
        chk("trip_def", 18'h00001, {17'h00000, o_overspeed_trip});
        i_out_freq    = 16'sh0000;
        i_band_low    = 16'h0032;
        i_band_up     = 16'h003C;
        i_detect_abs  = 1;
        i_closed_loop = 1;
        i_enable      = 1;
        settle();
        chk("speed_err", 18'h3FFFB, o_speed_err);
        chk("speed_fb", 18'h00035, {2'h0, o_speed_fb});
        chk("at_cl", 18'h00001, {17'h00000, o_at_speed});
        chk("loop_neg", 18'h3FFBB, 18'(o_loop_out));
        dir = 1;
        settle();
        chk("speed_err_rev", 18'h00005, o_speed_err);
        chk("at_cl_rev", 18'h00001, {17'h00000, o_at_speed});
        chk("loop_pos", 18'h0003D, 18'(o_loop_out));
        chk("pct_pos", 18'h0003D, 18'(o_torque_pct));
        i_enable = 0;
        sample();
        chk("loop_off", 18'h00000, {6'h00, o_loop_out});
        chk("pct_off", 18'h00000, {9'h000, o_torque_pct});
        i_enable      = 1;
        i_gain_custom = 1;
        i_d_coeff     = 16'h0010;
        i_fb_resolver = 1;
        i_res_angle   = 16'h0100;
        sample();
        chk("speed_fb_res", 18'h002A7, {2'h0, o_speed_fb});
        chk("err_deriv", 18'h3FF7B, o_speed_err);
        chk("loop_pfloor", 18'h3FFF7, 18'(o_loop_out));
        i_p_coeff  = 16'hFFFF;
        i_pct_gain = 16'hFFFF;
        sample();
        chk("err_deriv_back", 18'h00040, o_speed_err);
        chk("loop_max", 18'h007FE, 18'(o_loop_out));
        chk("pct_max", 18'h000C8, 18'(o_torque_pct));
        i_variant    = VAR_SERVO;
        i_trip_reset = 1;
        repeat (2) @(negedge i_clk);
        i_trip_reset = 0;
        i_res_angle  = 16'h03F4;
        sample();
        chk("speed_fb_hi", 18'h007D5, {2'h0, o_speed_fb});
        chk("trip_servo", 18'h00000, {17'h00000, o_overspeed_trip});
        i_variant   = VAR_VECTOR;
        i_res_angle = 16'h06E8;
        sample();
        chk("trip_vector", 18'h00001, {17'h00000, o_overspeed_trip});
        i_sw_freq   = SW_9K;
        i_res_angle = 16'h09DC;
        sample();
        chk("speed_fb_slow", 18'h005D8, {2'h0, o_speed_fb});
        i_closed_loop = 0;
        i_band_custom = 0;
        win(0, 100, 110, 3'h4);
        win(0, 100, 111, 3'h2);
        summarize();
    end
endmodule
